// ==== core/pmsc_top.sv ====
// Mains sensing, brownin/brownout, latch clear, X-cap and boost control.
// Assumes ADC samples and the AXI4-Lite master on sys_clk; pins are async.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pmsc_top import pmsc_pkg::*; #(
    parameter int MS_CYCLES = CLK_HZ / 1000 * TICK_MS,
    parameter int MSW       = 15
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    // Register bus
    input  wire pmsc_axi_req_s axi_req,
    output pmsc_axi_rsp_s      axi_rsp,
    // Sampled inputs
    input  wire logic          mains_smp_valid,
    input  wire logic [11:0]   mains_sense_pin,
    input  wire logic [9:0]    boost_drain_sense_pin,
    input  wire logic          boost_out_valid,
    input  wire logic [11:0]   boost_output_sense_pin,
    // Comparator pins
    input  wire logic          mains_zc_pin,
    input  wire logic          controller_supply_pin,
    input  wire logic          boost_current_sense_pin,
    // Outputs
    output logic               boost_gate,
    output logic               llc_enable,
    output logic               xcap_discharge,
    output logic               sense_sel,
    output logic               fast_latch_clear,
    output logic [9:0]         error_amp_output
);
    typedef struct packed {
        logic [1:0]              sz;
        logic [1:0]              ssup;
        logic [1:0]              sdmg;
        logic                    zc_d;
        logic                    zpar;
        logic [MSW-1:0]          ms_cnt;
        logic                    tick;
        logic                    sel;
        logic [11:0]             pk;
        logic [14:0]             acc;
        logic [2:0]              nacc;
        logic [11:0]             lvl;
        logic [19:0]             hw_cnt;
        logic [19:0]             hw_len;
        logic                    run;
        logic                    bo;
        logic [9:0]              comp;
        pmsc_bst_e               st;
        logic [11:0]             on_cnt;
        logic [7:0]              per;
        logic [11:0]             ton;
        logic [9:0]              dprev;
        logic [9:0]              smax;
        logic                    gate;
        logic                    llc;
        logic                    xcap;
        logic                    pclr;
        logic [NWREG-1:0][31:0]  regs;
        pmsc_axi_rsp_s           rsp;
    } pmsc_st_s;
    pmsc_st_s st_q;
    pmsc_st_s st_d;
    logic t_bo, t_flr, t_xc, t_moff, t_dmg, t_ring;
    // Configuration fields
    logic [31:0] r_ct, r_dl, r_bt;
    logic [1:0]  filt;
    logic [11:0] bi_lvl, hys;
    logic [8:0]  xc_ld;
    assign r_ct   = st_q.regs[0];
    assign r_dl   = st_q.regs[2];
    assign r_bt   = st_q.regs[3];
    assign filt   = r_ct[CT_FILT +: 2];
    assign bi_lvl = st_q.regs[1][BR_IN +: 12];
    assign hys    = st_q.regs[1][BR_HYS +: 12];
    assign xc_ld  = 9'((r_ct[CT_XSEL +: 2] + 3'd1) * XCAP_STEP_MS);
    // Mains measurement
    logic        zc_rise, below_bo;
    logic [11:0] smp_sc, bo_thr;
    logic [14:0] acc_n;
    assign zc_rise = st_q.sz[1] & ~st_q.zc_d;
    assign smp_sc  = r_ct[CT_R10] ? {1'b0, mains_sense_pin[11:1]}
                                  : mains_sense_pin;
    assign acc_n   = st_q.acc + {3'b000, st_q.pk};
    assign bo_thr  = (bi_lvl > hys) ? 12'(bi_lvl - hys) : 12'h000;
    assign below_bo = st_q.lvl < bo_thr;
    // On-time terms
    logic [21:0] lin_p;
    logic [19:0] mc_p;
    logic [13:0] ton_sum;
    logic        pfi_on;
    assign lin_p = st_q.regs[4][TN_MAX +: 12] * st_q.comp;
    assign mc_p  = st_q.regs[4][TN_MCG +: 8] * (12'hFFF - st_q.lvl);
    assign pfi_on = r_ct[CT_PFI] && (st_q.hw_cnt > {1'b0, st_q.hw_len[19:1]});
    assign ton_sum = {2'b00, lin_p[21:10]} + {2'b00, mc_p[19:8]}
                   + (pfi_on ? {6'h00, st_q.regs[4][TN_PFI +: 8]}
                             : 14'h0000);
    // Error amplifier
    logic [11:0]        ea_ref;
    logic signed [14:0] ea_err, ea_sh, ea_new;
    logic               ea_low;
    assign ea_ref = st_q.regs[5][EA_REF +: 12];
    assign ea_err = $signed({3'b000, ea_ref})
                  - $signed({3'b000, boost_output_sense_pin});
    assign ea_sh  = ea_err >>> st_q.regs[5][EA_GAIN +: 4];
    assign ea_low = ({1'b0, boost_output_sense_pin} + {1'b0, EA_BAND})
                  < {1'b0, ea_ref};
    assign ea_new = $signed({5'h00, st_q.comp})
                  + (ea_low ? (ea_sh <<< 1) : ea_sh);
    // Valley detection
    logic [9:0]  slope;
    logic        valley, per_ok;
    assign slope  = (boost_drain_sense_pin < st_q.dprev)
                  ? 10'(st_q.dprev - boost_drain_sense_pin) : 10'h000;
    assign valley = (st_q.smax != 10'h000) && ({slope, 3'b000}
                  <= 13'(st_q.smax * r_ct[CT_SENS +: 3]));
    assign per_ok = st_q.per >= r_bt[BT_PER +: 8];
    // Bus decode
    logic [2:0]  aw_ix, ar_ix;
    logic [31:0] status_w;
    assign aw_ix = axi_req.awaddr[4:2];
    assign ar_ix = axi_req.araddr[4:2];
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_LVL +: 12] = st_q.lvl;
        status_w[ST_RUN]       = st_q.run;
        status_w[ST_BO]        = st_q.bo;
        status_w[ST_XC]        = st_q.xcap;
        status_w[ST_SEL]       = st_q.sel;
        status_w[ST_COMP +: 10] = st_q.comp;
    end
    always_comb begin
        st_d = st_q;
        // Synchronisers and dividers
        st_d.sz   = {st_q.sz[0], mains_zc_pin};
        st_d.ssup = {st_q.ssup[0], controller_supply_pin};
        st_d.sdmg = {st_q.sdmg[0], boost_current_sense_pin};
        st_d.zc_d = st_q.sz[1];
        st_d.tick = 1'b0;
        if (st_q.ms_cnt == MSW'(MS_CYCLES - 1)) begin
            st_d.ms_cnt = '0;
            st_d.tick   = 1'b1;
        end else begin
            st_d.ms_cnt = MSW'(st_q.ms_cnt + 1'b1);
        end
        // Shared sense pin and peak tracking
        if (mains_smp_valid) begin
            st_d.sel = ~st_q.sel;
            if (!st_q.sel && smp_sc > st_q.pk) begin
                st_d.pk = smp_sc;
            end
        end
        if (zc_rise) begin
            st_d.zpar   = ~st_q.zpar;
            st_d.hw_len = st_q.hw_cnt;
            st_d.hw_cnt = 20'h0_0000;
            if (r_ct[CT_DUAL] || st_q.zpar) begin
                st_d.pk = 12'h000;
                if ({1'b0, st_q.nacc} == 4'((4'h1 << filt) - 4'h1)) begin
                    st_d.lvl  = 12'(acc_n >> filt);
                    st_d.acc  = 15'h0000;
                    st_d.nacc = 3'h0;
                end else begin
                    st_d.acc  = acc_n;
                    st_d.nacc = 3'(st_q.nacc + 1'b1);
                end
            end
        end else if (st_q.hw_cnt != 20'hF_FFFF) begin
            st_d.hw_cnt = 20'(st_q.hw_cnt + 1'b1);
        end
        // Brownin and brownout
        if (st_q.lvl > bi_lvl) begin
            st_d.run = 1'b1;
            st_d.bo  = 1'b0;
        end else if (t_bo) begin
            st_d.run = 1'b0;
            st_d.bo  = 1'b1;
        end
        st_d.llc  = !(st_q.bo && r_ct[CT_LLC]);
        st_d.pclr = st_q.ssup[1] || t_flr;
        st_d.xcap = t_xc;
        // Error amplifier update
        if (boost_out_valid) begin
            if (ea_new < 0) begin
                st_d.comp = 10'h000;
            end else if (ea_new > 15'sd1023) begin
                st_d.comp = 10'h3FF;
            end else begin
                st_d.comp = ea_new[9:0];
            end
        end
        st_d.ton = (ton_sum[13:12] != 2'b00) ? 12'hFFF : ton_sum[11:0];
        // Boost switching sequence
        st_d.dprev = boost_drain_sense_pin;
        if (st_q.per != 8'hFF) begin
            st_d.per = 8'(st_q.per + 1'b1);
        end
        unique case (st_q.st)
            S_IDLE: begin
                if (st_q.run && t_moff && per_ok) begin
                    st_d.st     = S_ON;
                    st_d.gate   = 1'b1;
                    st_d.on_cnt = 12'h000;
                    st_d.per    = 8'h00;
                end
            end
            S_ON: begin
                if (!st_q.run) begin
                    st_d.st   = S_IDLE;
                    st_d.gate = 1'b0;
                end else if ({1'b0, st_q.on_cnt} + 13'h0001
                             >= {1'b0, st_q.ton}) begin
                    st_d.st   = S_DEMAG;
                    st_d.gate = 1'b0;
                end else begin
                    st_d.on_cnt = 12'(st_q.on_cnt + 1'b1);
                end
            end
            S_DEMAG: begin
                if (!st_q.run) begin
                    st_d.st = S_IDLE;
                end else if (st_q.sdmg[1] || t_dmg) begin
                    st_d.st   = S_RING;
                    st_d.smax = 10'h000;
                end
            end
            S_RING: begin
                if (slope > st_q.smax) begin
                    st_d.smax = slope;
                end
                if (!st_q.run) begin
                    st_d.st = S_IDLE;
                end else if ((valley || t_ring) && t_moff && per_ok) begin
                    st_d.st     = S_ON;
                    st_d.gate   = 1'b1;
                    st_d.on_cnt = 12'h000;
                    st_d.per    = 8'h00;
                end
            end
        endcase
        // AXI4-Lite write
        st_d.rsp.awready = 1'b0;
        st_d.rsp.wready  = 1'b0;
        st_d.rsp.arready = 1'b0;
        if (st_q.rsp.bvalid && axi_req.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        if (st_q.rsp.awready && axi_req.awvalid && axi_req.wvalid) begin
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp  = RESP_SLVERR;
            if (aw_ix < 3'(NWREG)) begin
                st_d.rsp.bresp = RESP_OK;
                for (int i = 0; i < 4; i++) begin
                    if (axi_req.wstrb[i]) begin
                        st_d.regs[aw_ix][8*i +: 8] = axi_req.wdata[8*i +: 8];
                    end
                end
            end
        end else if (axi_req.awvalid && axi_req.wvalid
                     && !st_q.rsp.bvalid && !st_q.rsp.awready) begin
            st_d.rsp.awready = 1'b1;
            st_d.rsp.wready  = 1'b1;
        end
        // AXI4-Lite read
        if (st_q.rsp.rvalid && axi_req.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (st_q.rsp.arready && axi_req.arvalid) begin
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rresp  = RESP_OK;
            if (ar_ix < 3'(NWREG)) begin
                st_d.rsp.rdata = st_q.regs[ar_ix];
            end else if (ar_ix == OFF_STATUS[4:2]) begin
                st_d.rsp.rdata = status_w;
            end else begin
                st_d.rsp.rdata = 32'h0000_0000;
                st_d.rsp.rresp = RESP_SLVERR;
            end
        end else if (axi_req.arvalid && !st_q.rsp.rvalid
                     && !st_q.rsp.arready) begin
            st_d.rsp.arready = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q      <= '0;
            st_q.regs <= RST_REGS;
        end else begin
            st_q <= st_d;
        end
    end
    // Delay and timeout counters
    pmsc_timer #(.W(9)) u_bo (.sys_clk(sys_clk), .resetn(resetn),
        .tick(st_q.tick), .hold(below_bo && !st_q.bo),
        .load({1'b0, r_dl[DL_BO +: 8]}), .done(t_bo));
    pmsc_timer #(.W(9)) u_flr (.sys_clk(sys_clk), .resetn(resetn),
        .tick(st_q.tick), .hold(below_bo && st_q.st == S_IDLE),
        .load({1'b0, r_dl[DL_FLR +: 8]}), .done(t_flr));
    pmsc_timer #(.W(9)) u_xc (.sys_clk(sys_clk), .resetn(resetn),
        .tick(st_q.tick), .hold(st_q.bo && r_ct[CT_XEN]),
        .load(xc_ld), .done(t_xc));
    pmsc_timer #(.W(8)) u_moff (.sys_clk(sys_clk), .resetn(resetn),
        .tick(1'b1), .hold(st_q.st != S_ON),
        .load(r_bt[BT_MOFF +: 8]), .done(t_moff));
    pmsc_timer #(.W(8)) u_dmg (.sys_clk(sys_clk), .resetn(resetn),
        .tick(1'b1), .hold(st_q.st == S_DEMAG),
        .load(r_bt[BT_DMG +: 8]), .done(t_dmg));
    pmsc_timer #(.W(8)) u_ring (.sys_clk(sys_clk), .resetn(resetn),
        .tick(1'b1), .hold(st_q.st == S_RING),
        .load(r_bt[BT_RING +: 8]), .done(t_ring));
    assign axi_rsp          = st_q.rsp;
    assign boost_gate       = st_q.gate;
    assign llc_enable       = st_q.llc;
    assign xcap_discharge   = st_q.xcap;
    assign sense_sel        = st_q.sel;
    assign fast_latch_clear = st_q.pclr;
    assign error_amp_output = st_q.comp;
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_turn_on;
        $rose(st_q.gate);
    endsequence
    a_sense_alt: assert property (mains_smp_valid |=>
        sense_sel != $past(sense_sel)) else $error("sense pin not alternated");
    a_level_zc: assert property ($changed(st_q.lvl) |->
        $past(zc_rise)) else $error("level changed off a zero crossing");
    a_brown_order: assert property (bo_thr <= bi_lvl)
        else $error("brownout above brownin");
    a_start_run: assert property (s_turn_on |->
        $past(st_q.run)) else $error("boost started without brownin");
    a_bo_halt: assert property ($rose(st_q.bo) |=>
        !boost_gate && st_q.st == S_IDLE) else $error("boost ran in brownout");
    a_llc_off: assert property (st_q.bo && r_ct[CT_LLC] |=>
        !llc_enable) else $error("resonant stage left on");
    a_sup_clear: assert property (st_q.ssup[1] |=>
        fast_latch_clear) else $error("supply reset did not clear");
    a_min_off: assert property (s_turn_on |-> $past(t_moff)
        && $past(st_q.st) != S_ON) else $error("turn-on inside off-time");
    a_freq_cap: assert property (s_turn_on |->
        $past(st_q.per) >= $past(r_bt[BT_PER +: 8]))
        else $error("switching above frequency limit");
    a_demag_exit: assert property (st_q.st == S_DEMAG && st_q.run
        && t_dmg |=> st_q.st == S_RING) else $error("demag timeout ignored");
endmodule

// ==== core/pmsc_pkg.sv ====
// Shared constants and carrier types for the mains sense and boost control.
// Assumes a single 25 MHz clock and an AXI4-Lite master on the same clock.
package pmsc_pkg;

    // Timing
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_MS      = 1;
    localparam int XCAP_STEP_MS = 100;

    // Register byte offsets
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_BROWN  = 5'h04;
    localparam logic [4:0] OFF_DELAY  = 5'h08;
    localparam logic [4:0] OFF_BTIME  = 5'h0C;
    localparam logic [4:0] OFF_TON    = 5'h10;
    localparam logic [4:0] OFF_EAMP   = 5'h14;
    localparam logic [4:0] OFF_STATUS = 5'h18;
    localparam int         NWREG      = 6;

    // Control fields
    localparam int CT_DUAL = 0;
    localparam int CT_R10  = 1;
    localparam int CT_FILT = 2;
    localparam int CT_LLC  = 4;
    localparam int CT_PFI  = 5;
    localparam int CT_XSEL = 6;
    localparam int CT_XEN  = 8;
    localparam int CT_SENS = 9;
    // Other fields
    localparam int BR_IN   = 0;
    localparam int BR_HYS  = 16;
    localparam int DL_BO   = 0;
    localparam int DL_FLR  = 8;
    localparam int BT_MOFF = 0;
    localparam int BT_DMG  = 8;
    localparam int BT_RING = 16;
    localparam int BT_PER  = 24;
    localparam int TN_MAX  = 0;
    localparam int TN_PFI  = 16;
    localparam int TN_MCG  = 24;
    localparam int EA_REF  = 0;
    localparam int EA_GAIN = 12;
    localparam int ST_LVL  = 0;
    localparam int ST_RUN  = 12;
    localparam int ST_BO   = 13;
    localparam int ST_XC   = 14;
    localparam int ST_SEL  = 15;
    localparam int ST_COMP = 16;

    // Reset values
    localparam logic [31:0] RST_CTRL  = 32'h0000_0901;
    localparam logic [31:0] RST_BROWN = 32'h0040_0200;
    localparam logic [31:0] RST_DELAY = 32'h0000_C832;
    localparam logic [31:0] RST_BTIME = 32'h7D64_7D19;
    localparam logic [31:0] RST_TON   = 32'h1020_03E8;
    localparam logic [31:0] RST_EAMP  = 32'h0000_4800;
    localparam logic [NWREG-1:0][31:0] RST_REGS = {RST_EAMP, RST_TON,
        RST_BTIME, RST_DELAY, RST_BROWN, RST_CTRL};

    // Error amplifier low band and bus answers
    localparam logic [11:0] EA_BAND     = 12'h040;
    localparam logic [1:0]  RESP_OK     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ON    = 2'b01,
        S_DEMAG = 2'b10,
        S_RING  = 2'b11
    } pmsc_bst_e;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } pmsc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pmsc_axi_rsp_s;

endpackage

// ==== core/pmsc_timer.sv ====
// Hold timer: counts ticks while hold is high, flags when load is reached.
// Assumes tick is a one-cycle enable on sys_clk.
`timescale 1ns/10ps
module pmsc_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // Control
    input  wire logic         tick,
    input  wire logic         hold,
    input  wire logic [W-1:0] load,
    // Result
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } pmsc_tmr_s;

    pmsc_tmr_s st_q;
    pmsc_tmr_s st_d;

    always_comb begin
        st_d = st_q;
        if (!hold) begin
            st_d.cnt  = '0;
            st_d.done = 1'b0;
        end else begin
            if (tick && st_q.cnt < load) begin
                st_d.cnt = W'(st_q.cnt + 1'b1);
            end
            st_d.done = (st_q.cnt >= load);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;

    a_done_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(done) |-> $past(hold) && $past(st_q.cnt) >= $past(load))
        else $error("timer expired without full hold");
endmodule

// ==== testbench/pmsc_stage_model.sv ====
// Mains network and boost stage model for the mains sense bench.
// Assumes sys_clk of the controller; amp sets the mains sample level.
`timescale 1ns/10ps
module pmsc_stage_model (
    // Clock and control
    input  wire logic        sys_clk,
    input  wire logic [11:0] amp,
    input  wire logic        boost_gate,
    // To the controller
    output logic             mains_smp_valid,
    output logic [11:0]      mains_sense_pin,
    output logic             mains_zc_pin,
    output logic             boost_current_sense_pin,
    output logic [9:0]       boost_drain_sense_pin,
    output logic             boost_out_valid,
    output logic [11:0]      boost_output_sense_pin
);
    logic [7:0] t;
    logic [5:0] off;

    initial begin
        {t, off, mains_smp_valid, mains_sense_pin, mains_zc_pin} = '0;
        {boost_current_sense_pin, boost_drain_sense_pin} = '0;
        {boost_out_valid, boost_output_sense_pin} = '0;
    end

    // Sample pulses, zero crossings, demag after turn-off, drain ringing
    always @(posedge sys_clk) begin
        t <= t + 8'h01;
        off <= boost_gate ? 6'h00 : off + {5'h00, ~&off};
        mains_smp_valid <= t[2:0] == 3'h0;
        mains_sense_pin <= (t[2:0] == 3'h0) ? amp : ~amp;
        mains_zc_pin <= t[7:4] == 4'h0;
        boost_current_sense_pin <= !boost_gate && off > 6'h05;
        boost_drain_sense_pin <= {off[3:0] ^ {4{off[4]}}, 6'h00};
        boost_out_valid <= t[3:0] == 4'h0;
        boost_output_sense_pin <= 12'h700;
    end
endmodule

// ==== testbench/test_pmsc_top.sv ====
// Self-checking bench for the mains sense and boost control block.
// Assumes the stage model on the far side and AXI4-Lite tasks here.
`timescale 1ns/10ps
module test_pmsc_top import pmsc_pkg::*; ;
    logic          sys_clk = 1'h0;
    logic          resetn = 1'h0;
    logic          supply_low = 1'h0;
    logic [11:0]   amp = 12'h000;
    pmsc_axi_req_s req = '0;
    pmsc_axi_rsp_s rsp;
    logic [31:0]   rd;
    logic [1:0]    rr;
    logic          sel_old;
    int            fail_count = 0;
    int            tests_run = 0;
    logic          mains_smp_valid, mains_zc_pin, boost_current_sense_pin;
    logic          boost_out_valid, boost_gate, llc_enable, xcap_discharge;
    logic          sense_sel, fast_latch_clear;
    logic [11:0]   mains_sense_pin, boost_output_sense_pin;
    logic [9:0]    boost_drain_sense_pin, error_amp_output;

    pmsc_top #(.MS_CYCLES(10)) dut (
        .sys_clk, .resetn, .axi_req(req), .axi_rsp(rsp),
        .mains_smp_valid, .mains_sense_pin, .boost_drain_sense_pin,
        .boost_out_valid, .boost_output_sense_pin, .mains_zc_pin,
        .controller_supply_pin(supply_low), .boost_current_sense_pin,
        .boost_gate, .llc_enable, .xcap_discharge, .sense_sel,
        .fast_latch_clear, .error_amp_output);

    pmsc_stage_model stage (
        .sys_clk, .amp, .boost_gate, .mains_smp_valid, .mains_sense_pin,
        .mains_zc_pin, .boost_current_sense_pin, .boost_drain_sense_pin,
        .boost_out_valid, .boost_output_sense_pin);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic late();
        fail_count++;
        $display("FAIL %0t: wait ran out", $time);
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.awvalid <= 1'h1;
        req.wvalid  <= 1'h1;
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'h0;
            if (rsp.wready) req.wvalid <= 1'h0;
            n++;
            if (n > 200) late();
        end while (rsp.bvalid !== 1'h1);
        req.bready <= 1'h0;
        rr = rsp.bresp;
    endtask

    task automatic rdr(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.arvalid <= 1'h1;
        req.araddr  <= a;
        req.rready  <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'h0;
            n++;
            if (n > 200) late();
        end while (rsp.rvalid !== 1'h1);
        req.rready <= 1'h0;
        rd = rsp.rdata;
        rr = rsp.rresp;
    endtask

    // Reads status until the masked field matches, bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            rdr({27'h0, OFF_STATUS});
            n++;
            if (n > 2000) late();
        end while ((rd & m) !== v);
        chk(rd & m, v);
    endtask

    task automatic wgate(input logic v);
        for (int n = 0; boost_gate !== v; n++) begin
            if (n > 5000) late();
            @(posedge sys_clk);
        end
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        for (int i = 0; i < NWREG; i++) begin
            rdr(32'(i * 4));
            chk(rd, RST_REGS[i]);
        end
        rdr(32'h0000_001C);
        chk(rd, 32'h0000_0000);
        chk(rr, RESP_SLVERR);
        wr({27'h0, OFF_STATUS}, 32'hFFFF_FFFF);
        chk(rr, RESP_SLVERR);
        for (int n = 0; mains_smp_valid !== 1'h1 && n < 20; n++)
            @(posedge sys_clk);
        sel_old = sense_sel;
        @(posedge sys_clk);
        chk(sense_sel, !sel_old);
        amp <= 12'h400;
        poll(32'h1 << ST_RUN, 32'h1 << ST_RUN);
        poll(32'h0000_0FFF, 32'h0000_0400);
        wgate(1'h1);
        wgate(1'h0);
        wgate(1'h1);
        chk(llc_enable, 1'h1);
        supply_low <= 1'h1;
        repeat (6) @(posedge sys_clk);
        chk(fast_latch_clear, 1'h1);
        supply_low <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk(fast_latch_clear, 1'h0);
        wr({27'h0, OFF_CTRL}, RST_CTRL | 32'h0000_0012);
        chk(rr, RESP_OK);
        poll(32'h0000_0FFF, 32'h0000_0200);
        amp <= 12'h000;
        poll(32'h1 << ST_BO, 32'h1 << ST_BO);
        repeat (3) @(posedge sys_clk);
        chk(boost_gate, 1'h0);
        chk(llc_enable, 1'h0);
        chk(xcap_discharge, 1'h0);
        chk(fast_latch_clear, 1'h0);
        poll(32'h1 << ST_XC, 32'h1 << ST_XC);
        for (int n = 0; fast_latch_clear !== 1'h1; n++) begin
            if (n > 4000) late();
            @(posedge sys_clk);
        end
        chk(fast_latch_clear, 1'h1);
        chk(error_amp_output, 32'h0000_03FF);
        end_sim();
    end
endmodule
